// file: rtl/pvia_top.sv
// Priority vector interrupt arbiter with an AHB-Lite register slave
//
// Summary of operation
// RULE1: Normal table at 0x000004, 126 vectors
// RULE2: Each entry is a 24-bit handler address
// RULE3: Select bit 15 switches to table 0x000104
// RULE4: Vector location is base plus twice number
// RULE5: Reset bypasses arbiter, vector output is zero
// RULE6: Taken only if level exceeds core level
// RULE7: User levels 0-7, levels 8-15 traps
// RULE8: Traps fixed, one per level, above users
// RULE9: Level zero source is never taken
// RULE10: Core level is trap bit plus field
// RULE11: Field writable, N blocks levels up to N
// RULE12: Trap bit set by traps, software clears
// RULE13: Nesting disabled makes field write-ignored
// RULE14: Three-bit level per nibble, bit 3 zero
// RULE15: Level first, lower vector breaks ties
// RULE16: Preempt only with strictly higher level
// RULE17: One request line to the core
// RULE18: Software masks before changing source levels
// RULE19: Oscillator trap highest, DMA error lowest
// RULE20: Hold offer until acknowledge, then raise level
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "pvia_defs.svh"

module pvia_top #(parameter int NSRC = `PVIA_NUM_SRC)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [NSRC-1:0] src_req,
	input wire logic [`PVIA_NUM_TRAP-1:0] trap_req,
	input wire logic core_ack,
	output logic irq,
	output pvia_pkg::pvia_addr_t vec_addr,
	output pvia_pkg::pvia_vec_t vec_num,
	output pvia_pkg::pvia_lvl_t vec_level,
	output logic [2:0] core_level_field,
	output logic trap_level_bit
);
	import pvia_pkg::*;

	localparam int NPRIO = (NSRC + 3) / 4;
	localparam int NPEND = (NSRC + 31) / 32;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [NSRC-1:0] src_s1;
		logic [NSRC-1:0] src_s2;
		logic [`PVIA_NUM_TRAP-1:0] trap_s1;
		logic [`PVIA_NUM_TRAP-1:0] trap_s2;
		logic [NSRC-1:0][2:0] prio;
		logic alt_table_select;
		logic nest_dis;
		logic [2:0] lvl_field;
		logic trap_bit;
		pvia_hold_t hold;
		logic irq;
		pvia_addr_t vec_addr;
		pvia_vec_t vec_num;
		pvia_lvl_t vec_level;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] hrdata;
		logic rdy;
		logic resp;
	} pvia_state_t;

	pvia_state_t r;
	pvia_state_t next_r;

	pvia_arb_if #(.NSRC(NSRC)) arb_bus ();

	pvia_arb #(.NSRC(NSRC)) u_arb
	(
		.a(arb_bus.arb)
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic pvia_addr_t vec_loc(logic alt, pvia_vec_t v);
		pvia_addr_t base;
		base = alt ? `PVIA_ALTERNATE_VECTOR_TABLE_BASE : `PVIA_IVT_BASE; // see RULE1 see RULE3
		return base + {16'h0000, v, 1'b0}; // see RULE2 see RULE4
	endfunction

	function automatic logic in_range(logic [7:0] a, logic [7:0] base,
		int count);
		int off;
		off = int'(a) - int'(base);
		return off >= 0 && off < 4 * count && a[1:0] == 2'h0;
	endfunction

	function automatic int word_idx(logic [7:0] a, logic [7:0] base);
		return (int'(a) - int'(base)) / 4;
	endfunction

	function automatic logic [31:0] read_word(pvia_state_t s,
		logic [7:0] a);
		logic [31:0] w;
		int k;
		int idx;
		w = 32'h0000_0000;
		k = 0;
		idx = 0;
		if (a == `PVIA_OFF_CTRL2)
		begin
			w[`PVIA_ALT_BIT] = s.alt_table_select;
			w[`PVIA_NEST_DIS_BIT] = s.nest_dis;
		end
		else if (a == `PVIA_OFF_STATUS)
		begin
			w[`PVIA_LVL_LSB +: 3] = s.lvl_field; // see RULE10
		end
		else if (a == `PVIA_OFF_CORECTL)
		begin
			w[`PVIA_TRAP_BIT] = s.trap_bit; // see RULE10
		end
		else if (a == `PVIA_OFF_VECTOR)
		begin
			w[`PVIA_PEND_BIT] = s.irq;
			w[23:0] = s.vec_addr;
		end
		else if (a == `PVIA_OFF_TRAPPEND)
		begin
			w[`PVIA_NUM_TRAP-1:0] = s.trap_s2;
		end
		else if (in_range(a, `PVIA_OFF_SRCPEND, NPEND))
		begin
			k = word_idx(a, `PVIA_OFF_SRCPEND);
			for (int j = 0; j < 32; j++)
			begin
				idx = 32 * k + j;
				if (idx < NSRC)
					w[j] = s.src_s2[idx];
			end
		end
		else if (in_range(a, `PVIA_OFF_PRIO, NPRIO))
		begin
			k = word_idx(a, `PVIA_OFF_PRIO);
			// Bit 3 of each nibble is left at zero
			for (int j = 0; j < 4; j++)
			begin
				idx = 4 * k + j;
				if (idx < NSRC)
					w[4*j +: 3] = s.prio[idx]; // see RULE14
			end
		end
		return w;
	endfunction

	// ****************************************
	// Arbiter hookup
	// ****************************************
	assign arb_bus.pend = r.src_s2;
	assign arb_bus.prio = r.prio;
	assign arb_bus.trap = r.trap_s2;
	// A user level never has bit 3 set, so a raised trap bit masks all user sources
	assign arb_bus.core_lvl = {r.trap_bit, r.lvl_field}; // see RULE7

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		int k;
		int idx;
		logic take;
		k = 0;
		idx = 0;
		take = 1'b0;
		next_r = r;

		next_r.src_s1 = src_req;
		next_r.src_s2 = r.src_s1;
		next_r.trap_s1 = trap_req;
		next_r.trap_s2 = r.trap_s1;
		next_r.rdy = 1'b1;
		next_r.resp = 1'b0;

		// Data phase of a write
		if (r.dp_wr)
		begin
			if (r.dp_addr == `PVIA_OFF_CTRL2)
			begin
				next_r.alt_table_select = hwdata[`PVIA_ALT_BIT]; // see RULE3
				next_r.nest_dis = hwdata[`PVIA_NEST_DIS_BIT];
			end
			else if (r.dp_addr == `PVIA_OFF_STATUS)
			begin
				if (!r.nest_dis) // see RULE13
					next_r.lvl_field = hwdata[`PVIA_LVL_LSB +: 3]; // see RULE11
			end
			else if (r.dp_addr == `PVIA_OFF_CORECTL)
			begin
				// Software may only clear the trap bit
				next_r.trap_bit = r.trap_bit & hwdata[`PVIA_TRAP_BIT]; // see RULE12
			end
			else if (in_range(r.dp_addr, `PVIA_OFF_PRIO, NPRIO))
			begin
				k = word_idx(r.dp_addr, `PVIA_OFF_PRIO);
				// Changing levels while the request is offered is unsafe;
				// the offer keeps its latched vector regardless
				for (int j = 0; j < 4; j++)
				begin
					idx = 4 * k + j;
					if (idx < NSRC)
						next_r.prio[idx] = hwdata[4*j +: 3]; // see RULE14 see RULE18
				end
			end
		end

		// Address phase; reads answer from a flop in the data phase
		take = hsel && htrans[1] && hready;
		next_r.dp_wr = take && hwrite;
		next_r.dp_addr = take ? haddr[7:0] : r.dp_addr;
		if (take && !hwrite)
			next_r.hrdata = read_word(r, haddr[7:0]);

		// Offer to the core; acknowledge is applied after the
		// software write so the hardware raise wins a collision
		unique case (r.hold)
			PVIA_IDLE:
			begin
				if (arb_bus.win) // see RULE17
				begin
					next_r.hold = PVIA_OFFER;
					next_r.irq = 1'b1;
					next_r.vec_num = arb_bus.win_vec;
					next_r.vec_level = arb_bus.win_lvl;
					next_r.vec_addr = vec_loc(r.alt_table_select,
						arb_bus.win_vec); // see RULE4
				end
			end
			PVIA_OFFER:
			begin
				// Held stable until taken; no re-arbitration meanwhile
				if (core_ack) // see RULE20
				begin
					next_r.hold = PVIA_IDLE;
					next_r.irq = 1'b0;
					// Raising the level makes later equal levels wait
					next_r.lvl_field = r.vec_level[2:0]; // see RULE16
					if (r.vec_level[3])
						next_r.trap_bit = 1'b1; // see RULE12
				end
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r <= '0;
			r.hold <= PVIA_IDLE;
			r.lvl_field <= `PVIA_RST_LVL;
			r.vec_addr <= `PVIA_RESET_PC; // see RULE5
			r.rdy <= 1'b1;
		end
		else
			r <= next_r;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign hrdata = r.hrdata;
	assign hreadyout = r.rdy;
	assign hresp = r.resp;
	assign irq = r.irq;
	assign vec_addr = r.vec_addr;
	assign vec_num = r.vec_num;
	assign vec_level = r.vec_level;
	assign core_level_field = r.lvl_field;
	assign trap_level_bit = r.trap_bit;

endmodule

// file: shared/pvia_defs.svh
// Constants for the priority vector interrupt arbiter
`ifndef PVIA_DEFS_SVH
`define PVIA_DEFS_SVH

// ****************************************
// Vector tables
// ****************************************
`define PVIA_IVT_BASE 24'h000004
`define PVIA_ALTERNATE_VECTOR_TABLE_BASE 24'h000104
`define PVIA_RESET_PC 24'h000000
`define PVIA_NUM_VEC 126
`define PVIA_NUM_TRAP 8
`define PVIA_NUM_SRC 118
`define PVIA_TOP_LVL 4'hF

// ****************************************
// Register byte offsets
// ****************************************
`define PVIA_OFF_CTRL2 8'h00
`define PVIA_OFF_STATUS 8'h04
`define PVIA_OFF_CORECTL 8'h08
`define PVIA_OFF_VECTOR 8'h0C
`define PVIA_OFF_TRAPPEND 8'h10
`define PVIA_OFF_SRCPEND 8'h20
`define PVIA_OFF_PRIO 8'h40

// ****************************************
// Field positions and reset values
// ****************************************
`define PVIA_ALT_BIT 15
`define PVIA_NEST_DIS_BIT 14
`define PVIA_LVL_LSB 5
`define PVIA_TRAP_BIT 3
`define PVIA_PEND_BIT 31
`define PVIA_RST_LVL 3'h0

`endif

// file: shared/pvia_pkg.sv
// Types shared by the interrupt arbiter modules
package pvia_pkg;

	typedef logic [3:0] pvia_lvl_t;
	typedef logic [23:0] pvia_addr_t;
	typedef logic [6:0] pvia_vec_t;
	typedef enum logic {PVIA_IDLE, PVIA_OFFER} pvia_hold_t;

endpackage

// file: shared/pvia_arb_if.sv
// Signals between the register/offer logic and the arbiter core
`timescale 1ns/1ps
`include "pvia_defs.svh"

interface pvia_arb_if #(parameter int NSRC = `PVIA_NUM_SRC);
	import pvia_pkg::*;

	logic [NSRC-1:0] pend;
	logic [NSRC-1:0][2:0] prio;
	logic [`PVIA_NUM_TRAP-1:0] trap;
	pvia_lvl_t core_lvl;
	logic win;
	pvia_vec_t win_vec;
	pvia_lvl_t win_lvl;

	modport arb (input pend, input prio, input trap, input core_lvl,
		output win, output win_vec, output win_lvl);
	modport top (output pend, output prio, output trap, output core_lvl,
		input win, input win_vec, input win_lvl);

endinterface

// file: rtl/pvia_arb.sv
// Combinational ranking of pending traps and user sources
`timescale 1ns/1ps
`include "pvia_defs.svh"

module pvia_arb #(parameter int NSRC = `PVIA_NUM_SRC)
(
	pvia_arb_if.arb a
);
	import pvia_pkg::*;

	logic found;
	pvia_vec_t best_vec;
	pvia_lvl_t best_lvl;

	always_comb
	begin
		found = 1'b0;
		best_vec = '0;
		best_lvl = '0;
		// Descending scan with >= leaves the lowest vector on a tie
		for (int i = NSRC - 1; i >= 0; i--)
		begin
			if (a.pend[i] && a.prio[i] != 3'h0 &&
				{1'b0, a.prio[i]} >= best_lvl) // see RULE9 see RULE15
			begin
				found = 1'b1;
				best_lvl = {1'b0, a.prio[i]};
				best_vec = 7'(`PVIA_NUM_TRAP + i);
			end
		end
		// Traps hold fixed levels above every user level, one per level
		for (int t = `PVIA_NUM_TRAP - 1; t >= 0; t--)
		begin
			if (a.trap[t]) // see RULE8 see RULE19
			begin
				found = 1'b1;
				best_lvl = `PVIA_TOP_LVL - 4'(t);
				best_vec = 7'(t);
			end
		end
		a.win = found && best_lvl > a.core_lvl; // see RULE6
		a.win_vec = best_vec;
		a.win_lvl = best_lvl;
	end

endmodule

// file: sim/pvia_core_model.sv
// Core model that takes the offer after a set wait
`timescale 1ns/1ps
module pvia_core_model
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic irq,
	input wire logic [3:0] wait_cyc,
	output logic core_ack
);
	logic [3:0] cnt;
	logic hit;
	assign hit = irq && !core_ack && cnt == wait_cyc;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt <= 4'h0;
			core_ack <= 1'b0;
		end
		else
		begin
			// One pulse only, so the core never takes one offer twice
			core_ack <= hit;
			cnt <= (irq && !core_ack && !hit) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// file: sim/pvia_top_chk.sv
// Checker of the arbiter offer to the core
`timescale 1ns/1ps
module pvia_top_chk
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic core_ack,
	input wire logic irq,
	input wire pvia_pkg::pvia_addr_t vec_addr,
	input wire pvia_pkg::pvia_vec_t vec_num,
	input wire pvia_pkg::pvia_lvl_t vec_level,
	input wire logic [2:0] core_level_field,
	input wire logic trap_level_bit
);
	import pvia_pkg::*;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_vec_addr_map:
	assert property (irq |-> vec_addr == 24'h4 + {vec_num, 1'b0}
		|| vec_addr == 24'h104 + {vec_num, 1'b0}) else $error("addr");
	a_offer_hold:
	assert property (irq && !core_ack |=> irq && $stable(vec_num)
		&& $stable(vec_addr)) else $error("hold");
	a_ack_drop:
	assert property (irq && core_ack |=> !irq) else $error("drop");
	a_level_above:
	assert property ($rose(irq) |-> vec_level > {$past(trap_level_bit),
		$past(core_level_field)}) else $error("level");
	a_level_raise:
	assert property (irq && core_ack |=> {trap_level_bit,
		core_level_field} == $past(vec_level)) else $error("raise");
	a_trap_fixed:
	assert property (irq && vec_num < 8 |-> vec_level + vec_num == 7'hF)
		else $error("trap");
	a_user_range:
	assert property (irq && vec_num > 7 |-> vec_level inside {[1:7]})
		else $error("user");
	a_trap_bit_set:
	assert property ($rose(trap_level_bit) |-> $past(core_ack)
		&& $past(vec_level) > 4'h7) else $error("bit");
	cover property ($rose(irq) && vec_num < 8);
	cover property ($rose(irq) && vec_addr[8]);
	cover property (irq && core_ack);
endmodule
bind pvia_top pvia_top_chk pvia_top_chk_inst (.hclk(hclk),
	.hresetn(hresetn), .core_ack(core_ack), .irq(irq),
	.vec_addr(vec_addr), .vec_num(vec_num), .vec_level(vec_level),
	.core_level_field(core_level_field),
	.trap_level_bit(trap_level_bit));

// file: sim/pvia_top_tb.sv
// Testbench of the interrupt arbiter
`timescale 1ns/1ps
module pvia_top_tb;
	import pvia_pkg::*;
	logic hclk, hresetn, hwrite, hreadyout, hresp, core_ack, irq, tlb;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [15:0] src_req;
	logic [7:0] trap_req;
	logic [3:0] wait_cyc;
	logic [2:0] clf;
	pvia_addr_t vec_addr;
	pvia_vec_t vec_num;
	pvia_lvl_t vec_level;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	pvia_top #(.NSRC(16)) pvia_top_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.src_req(src_req), .trap_req(trap_req), .core_ack(core_ack),
		.irq(irq), .vec_addr(vec_addr), .vec_num(vec_num),
		.vec_level(vec_level), .core_level_field(clf),
		.trap_level_bit(tlb));
	pvia_core_model pvia_core_model_inst (.hclk(hclk), .hresetn(hresetn),
		.irq(irq), .wait_cyc(wait_cyc), .core_ack(core_ack));
	// ****
	// Shared tasks
	// ****
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic offer(input logic [6:0] n, input logic [3:0] l,
		input logic [23:0] b);
		int i;
		for (i = 0; i < 50 && irq !== 1'b1; i++)
			@(posedge hclk);
		chk(irq, 1);
		chk(vec_num, n);
		chk(vec_level, l);
		chk(vec_addr, b + 2 * n);
		for (i = 0; i < 50 && irq === 1'b1; i++)
			@(posedge hclk);
		chk(clf, l[2:0]);
	endtask
	task automatic quiet;
		repeat (10) @(posedge hclk);
		chk(irq, 0);
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset;
		chk(vec_addr, 0);
		chk({hresp, hreadyout}, 32'h1);
		bus(1, 8'h40, 32'hFFFFFFFF);
		bus(0, 8'h40, 0);
		chk(r, 32'h00007777);
		bus(0, 8'h3C, 0);
		chk(r, 0);
		bus(1, 8'h40, 0);
		src_req <= 16'h1;
		quiet;
		// Drop the request so it clears on the same edge the next level write lands on
		src_req <= 0;
		$display("reset test done");
	endtask
	task automatic t_rank;
		bus(1, 8'h40, 32'h553);
		src_req <= 16'h7;
		offer(9, 5, 24'h4);
		src_req <= 16'h5;
		quiet;
		bus(1, 8'h04, 0);
		offer(10, 5, 24'h4);
		src_req <= 16'h1;
		bus(1, 8'h04, 32'h60);
		bus(0, 8'h04, 0);
		chk(r, 32'h60);
		quiet;
		bus(1, 8'h04, 32'h40);
		offer(8, 3, 24'h4);
		bus(1, 8'h00, 32'h8000);
		bus(1, 8'h04, 0);
		offer(8, 3, 24'h104);
		src_req <= 0;
		$display("rank test done");
	endtask
	task automatic t_trap;
		bus(1, 8'h00, 0);
		bus(1, 8'h04, 0);
		bus(1, 8'h40, 32'h7);
		src_req <= 16'h1;
		trap_req <= 8'h22;
		offer(1, 14, 24'h4);
		chk(tlb, 1);
		trap_req <= 8'h20;
		quiet;
		bus(0, 8'h10, 0);
		chk(r, 32'h20);
		bus(1, 8'h08, 0);
		offer(5, 10, 24'h4);
		trap_req <= 0;
		bus(1, 8'h08, 0);
		offer(8, 7, 24'h4);
		src_req <= 0;
		bus(1, 8'h08, 32'h8);
		// The write lands on the edge the task returns on
		@(posedge hclk);
		chk(tlb, 0);
		bus(1, 8'h00, 32'h4000);
		bus(1, 8'h04, 32'h20);
		@(posedge hclk);
		chk(clf, 7);
		$display("trap test done");
	endtask
	initial
	begin
		hclk = 0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			end_of_test;
		end
	end
	initial
	begin
		hresetn = 0;
		htrans = 0;
		haddr = 0;
		hwrite = 0;
		hwdata = 0;
		src_req = 0;
		trap_req = 0;
		wait_cyc = 4'h2;
		repeat (12) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		t_reset;
		t_rank;
		t_trap;
		end_of_test;
	end
endmodule
